// file: logic/exec_response_formatter.sv
// response formatter of the programming executive: header build, serial send, nvm control
`include "resp_regs.svh"
`default_nettype none

// Functional notes
// - successful command answers with result opcode 1h
// - failing recognised command answers opcode 2h, cause in query_error_byte
// - unrecognised command answers with unknown_command_reply opcode 3h
// - response is two 16-bit header words, then any data words
// - result opcode is a 4-bit field of the first word
// - first word echoes the 4-bit command opcode
// - first word holds query_error_byte: query data or error code
// - blank_check_query and version_query always pass, result in query_error_byte
// - blank_check_query byte is F0h if blank, 0Fh if not
// - version_query byte is major nibble high, minor nibble low
// - successful non-query command gives query_error_byte 0h
// - failed verify of row or id program gives query_error_byte 1h
// - any other executive error gives query_error_byte 2h
// - length counts all 16-bit words including both header words
// - all responses are two words except program_read_command
// - odd N read: length is 3*(N+1)/2 + 2
// - even N read: length is 3*N/2 + 2
// - one command outstanding; one written before the response ends is ignored
// - nvm_control_reg bit 15 starts a cycle; hardware clears it when done
// - row_program_command verifies written data before responding
module exec_response_formatter (
  input  wire logic        clk,            // 100 MHz device clock
  input  wire logic        rstn,           // async reset, active low
  input  wire logic        hsel,           // ahb slave select
  input  wire logic [31:0] haddr,          // ahb address
  input  wire logic [1:0]  htrans,         // ahb transfer type
  input  wire logic        hwrite,         // ahb write
  input  wire logic [2:0]  hsize,          // ahb size, word only
  input  wire logic [31:0] hwdata,         // ahb write data
  input  wire logic        hready,         // ahb bus ready
  output logic             hreadyout,      // ahb slave ready
  output logic             hresp,          // ahb response, always okay
  output logic [31:0]      hrdata,         // ahb read data
  input  wire logic        link_clk,       // programmer serial clock
  output logic             link_dout,      // serial response data
  output logic             link_dout_oe,   // high while driving response
  input  wire logic        nvm_done,       // flash cycle finished pulse
  output logic             nvm_start       // one-cycle flash cycle start
);

  //////////////////////////////////////////////////////////////////////////////
  // ahb slave
  resp_pkg::ahb_req_t req_r;
  logic [31:0]        rdata_nxt;
  logic               cmd_wr;
  logic               data_wr;
  logic               nvm_wr;
  logic               ver_wr;
  logic               addr_take;

  logic [7:0]           ver_r;
  logic [15:0]          nvm_r;
  logic [15:0]          data_r;
  logic                 data_full_r;
  logic                 underrun_r;
  resp_pkg::tx_state_t  state_r;
  logic [15:0]          sh_r;
  logic [3:0]           bit_r;
  logic [15:0]          len_r;
  logic [15:0]          left_r;
  logic                 take_data;
  logic                 word_end;

  assign addr_take = hsel && htrans[1] && hready;
  assign cmd_wr    = req_r.valid && req_r.write && (req_r.addr == `RESP_CMD_OFS);
  assign data_wr   = req_r.valid && req_r.write && (req_r.addr == `RESP_DATA_OFS);
  assign nvm_wr    = req_r.valid && req_r.write && (req_r.addr == `RESP_NVM_OFS);
  assign ver_wr    = req_r.valid && req_r.write && (req_r.addr == `RESP_VER_OFS);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      req_r <= '0;
    end else begin
      req_r.valid <= addr_take;
      req_r.write <= hwrite;
      req_r.addr  <= haddr[11:0];
    end
  end

  // read data is captured at the address phase so the data phase needs no wait
  always_comb begin
    rdata_nxt = 32'h00000000;
    unique case (haddr[11:0])
      `RESP_VER_OFS:  rdata_nxt = {24'h000000, ver_r};
      `RESP_NVM_OFS:  rdata_nxt = {16'h0000, nvm_r};
      `RESP_STAT_OFS: rdata_nxt = {left_r, 12'h000, underrun_r, data_full_r, state_r};
      default:        rdata_nxt = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_take && !hwrite) begin
        hrdata <= rdata_nxt;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ver_r <= `RESP_VER_RST;
    end else if (ver_wr) begin
      ver_r <= hwdata[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // nvm control: bit 15 starts a cycle and stays set until the flash reports done
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nvm_r     <= `RESP_NVM_RST;
      nvm_start <= 1'b0;
    end else begin
      nvm_start <= nvm_wr && hwdata[`RESP_NVM_WR_BIT] && (!nvm_r[`RESP_NVM_WR_BIT] || nvm_done);
      if (nvm_wr) begin
        // software cannot stop a cycle; a done in the same cycle still ends it, else busy sticks
        nvm_r <= {hwdata[15] | (nvm_r[15] & !nvm_done), hwdata[14:0]};
      end else if (nvm_done) begin
        nvm_r[`RESP_NVM_WR_BIT] <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // header build
  resp_pkg::outcome_t kind;
  resp_pkg::hdr_word_t hdr;
  logic [15:0] n_words;
  logic [16:0] half_n;
  logic [16:0] len_wide;
  logic [15:0] len_nxt;

  assign kind    = resp_pkg::outcome_t'(hwdata[`RESP_CMD_KIND_LSB +: 3]);
  assign n_words = hwdata[`RESP_CMD_N_LSB +: 16];

  always_comb begin
    hdr.echo = hwdata[`RESP_CMD_ECHO_LSB +: 4];
    hdr.opcode = `RESP_OP_PASS;
    hdr.qe = `RESP_QE_NONE;
    unique case (kind)
      resp_pkg::K_VERIFY: begin
        hdr.opcode = `RESP_OP_FAIL;
        hdr.qe = `RESP_QE_VERIFY;
      end
      resp_pkg::K_ERROR: begin
        hdr.opcode = `RESP_OP_FAIL;
        hdr.qe = `RESP_QE_OTHER;
      end
      resp_pkg::K_UNKNOWN, resp_pkg::K_SPARE: begin
        hdr.opcode = `RESP_OP_UNKNOWN;
      end
      resp_pkg::K_BLANK: begin
        hdr.qe = hwdata[`RESP_CMD_BLANK] ? `RESP_QE_BLANK : `RESP_QE_NOTBLANK;
      end
      resp_pkg::K_VERSION: begin
        hdr.qe = ver_r;
      end
      default: begin
        hdr.qe = `RESP_QE_NONE;
      end
    endcase
  end

  // packed format: two instruction words fill three 16-bit words
  always_comb begin
    half_n   = ({1'b0, n_words} + {16'h0000, n_words[0]}) >> 1;
    len_wide = (half_n << 1) + half_n + {1'b0, `RESP_HDR_WORDS};
    len_nxt  = (kind == resp_pkg::K_READ) ? len_wide[15:0] : `RESP_HDR_WORDS;
  end

  //////////////////////////////////////////////////////////////////////////////
  // link clock sampling; first stage feeds only the second
  logic lc_s1;
  logic lc_s2;
  logic lc_s3;
  logic lc_fall;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lc_s1 <= 1'b0;
      lc_s2 <= 1'b0;
      lc_s3 <= 1'b0;
    end else begin
      lc_s1 <= link_clk;
      lc_s2 <= lc_s1;
      lc_s3 <= lc_s2;
    end
  end

  assign lc_fall  = lc_s3 && !lc_s2;
  assign word_end = lc_fall && (bit_r == 4'hF) && (state_r != resp_pkg::S_IDLE);
  assign take_data = word_end && (left_r != 16'h0000) && (state_r != resp_pkg::S_HDR0);

  //////////////////////////////////////////////////////////////////////////////
  // data holding word for read responses; writes while full are dropped unless the sender takes the word in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_r      <= 16'h0000;
      data_full_r <= 1'b0;
    end else begin
      if (data_wr && (!data_full_r || take_data)) begin
        data_r      <= hwdata[15:0];
        data_full_r <= 1'b1;
      end else if (take_data) begin
        data_full_r <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // response sender: bit changes on link falling edge, msb first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r      <= resp_pkg::S_IDLE;
      sh_r         <= 16'h0000;
      bit_r        <= 4'h0;
      len_r        <= 16'h0000;
      left_r       <= 16'h0000;
      underrun_r   <= 1'b0;
      link_dout_oe <= 1'b0;
    end else begin
      unique case (state_r)
        resp_pkg::S_IDLE: begin
          // a command while busy is ignored: only one outstanding
          if (cmd_wr) begin
            sh_r         <= hdr;
            len_r        <= len_nxt;
            left_r       <= len_nxt - `RESP_HDR_WORDS;
            bit_r        <= 4'h0;
            underrun_r   <= 1'b0;
            link_dout_oe <= 1'b1;
            state_r      <= resp_pkg::S_HDR0;
          end
        end
        resp_pkg::S_HDR0: begin
          if (lc_fall) begin
            bit_r <= bit_r + 4'h1;
            sh_r  <= {sh_r[14:0], 1'b0};
            if (word_end) begin
              sh_r    <= len_r;
              state_r <= resp_pkg::S_HDR1;
            end
          end
        end
        resp_pkg::S_HDR1, resp_pkg::S_DATA: begin
          if (lc_fall) begin
            bit_r <= bit_r + 4'h1;
            sh_r  <= {sh_r[14:0], 1'b0};
            if (word_end) begin
              if (left_r == 16'h0000) begin
                link_dout_oe <= 1'b0;
                state_r      <= resp_pkg::S_IDLE;
              end else begin
                // empty holder sends zero; software must stay ahead of the link
                sh_r       <= data_full_r ? data_r : 16'h0000;
                underrun_r <= underrun_r | !data_full_r;
                left_r     <= left_r - 16'h0001;
                state_r    <= resp_pkg::S_DATA;
              end
            end
          end
        end
      endcase
    end
  end

  assign link_dout = sh_r[15];

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  logic start;
  assign start = cmd_wr && (state_r == resp_pkg::S_IDLE);

  property p_pass;
    @(posedge clk) disable iff (!rstn)
      start && kind == resp_pkg::K_OK |=> sh_r[15:12] == 4'h1 && sh_r[7:0] == 8'h00;
  endproperty
  a_pass: assert property (p_pass) else $error("pass header wrong");

  property p_verify;
    @(posedge clk) disable iff (!rstn)
      start && kind == resp_pkg::K_VERIFY |=> sh_r[15:12] == 4'h2 && sh_r[7:0] == 8'h01;
  endproperty
  a_verify: assert property (p_verify) else $error("verify fail header wrong");

  property p_other;
    @(posedge clk) disable iff (!rstn)
      start && kind == resp_pkg::K_ERROR |=> sh_r[15:12] == 4'h2 && sh_r[7:0] == 8'h02;
  endproperty
  a_other: assert property (p_other) else $error("error header wrong");

  property p_unknown;
    @(posedge clk) disable iff (!rstn)
      start && kind == resp_pkg::K_UNKNOWN |=> sh_r[15:12] == 4'h3;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown reply wrong");

  property p_blank;
    @(posedge clk) disable iff (!rstn)
      start && kind == resp_pkg::K_BLANK |=> sh_r[15:12] == 4'h1 &&
        sh_r[7:0] == ($past(hwdata[8]) ? 8'hF0 : 8'h0F);
  endproperty
  a_blank: assert property (p_blank) else $error("blank query byte wrong");

  property p_echo;
    @(posedge clk) disable iff (!rstn)
      start |=> sh_r[11:8] == $past(hwdata[3:0]) && link_dout_oe;
  endproperty
  a_echo: assert property (p_echo) else $error("command echo wrong");

  property p_len;
    @(posedge clk) disable iff (!rstn)
      start && kind != resp_pkg::K_READ |=> len_r == 16'h0002 && left_r == 16'h0000;
  endproperty
  a_len: assert property (p_len) else $error("short length wrong");

  property p_len_odd;
    @(posedge clk) disable iff (!rstn)
      start && kind == resp_pkg::K_READ && hwdata[16] && hwdata[31:16] < 16'h0100
        |=> len_r == 16'(3 * ($past(hwdata[31:16]) + 1) / 2 + 2);
  endproperty
  a_len_odd: assert property (p_len_odd) else $error("odd read length wrong");

  property p_nvm_clear;
    @(posedge clk) disable iff (!rstn)
      nvm_done && !nvm_wr |=> !nvm_r[15];
  endproperty
  a_nvm_clear: assert property (p_nvm_clear) else $error("nvm busy bit not cleared");

  property p_hdr1;
    @(posedge clk) disable iff (!rstn)
      state_r == resp_pkg::S_HDR0 && word_end |=> state_r == resp_pkg::S_HDR1 && sh_r == len_r;
  endproperty
  a_hdr1: assert property (p_hdr1) else $error("length word not second");

  c_read: cover property (@(posedge clk) disable iff (!rstn) start && kind == resp_pkg::K_READ);
  c_data: cover property (@(posedge clk) disable iff (!rstn) state_r == resp_pkg::S_DATA);
  c_nvm:  cover property (@(posedge clk) disable iff (!rstn) nvm_r[15] && nvm_done);

endmodule
`default_nettype wire

// file: logic/resp_regs.svh
// register offsets, field positions, codes and reset values of the response formatter
`ifndef RESP_REGS_SVH
`define RESP_REGS_SVH

`define RESP_CMD_OFS      12'h000
`define RESP_VER_OFS      12'h004
`define RESP_DATA_OFS     12'h008
`define RESP_STAT_OFS     12'h00C
`define RESP_NVM_OFS      12'h010

`define RESP_CMD_ECHO_LSB 0
`define RESP_CMD_KIND_LSB 4
`define RESP_CMD_BLANK    8
`define RESP_CMD_N_LSB    16
`define RESP_NVM_WR_BIT   15

`define RESP_OP_PASS      4'h1
`define RESP_OP_FAIL      4'h2
`define RESP_OP_UNKNOWN   4'h3
`define RESP_QE_NONE      8'h00
`define RESP_QE_VERIFY    8'h01
`define RESP_QE_OTHER     8'h02
`define RESP_QE_BLANK     8'hF0
`define RESP_QE_NOTBLANK  8'h0F
`define RESP_HDR_WORDS    16'h0002

`define RESP_VER_RST      8'h10
`define RESP_NVM_RST      16'h0000

`endif

// file: logic/resp_pkg.sv
// types shared by the response formatter
`default_nettype none
package resp_pkg;
  typedef enum logic [2:0] {
    K_OK      = 3'b000,
    K_VERIFY  = 3'b001,
    K_ERROR   = 3'b010,
    K_UNKNOWN = 3'b011,
    K_BLANK   = 3'b100,
    K_VERSION = 3'b101,
    K_READ    = 3'b110,
    K_SPARE   = 3'b111
  } outcome_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_HDR0 = 2'b01,
    S_HDR1 = 2'b10,
    S_DATA = 2'b11
  } tx_state_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
  } ahb_req_t;

  typedef struct packed {
    logic [3:0] opcode;
    logic [3:0] echo;
    logic [7:0] qe;
  } hdr_word_t;
endpackage
`default_nettype wire

// file: tb/prog_model.sv
// behavioural programmer that clocks response frames out of the device
`default_nettype none
module prog_model (
  output var logic link_clk,     // serial clock, low between frames
  input  wire logic link_dout,   // response bit
  input  wire logic link_dout_oe // device drives the line
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] rx [0:15];
  logic        oe_lost;
  initial begin
    link_clk = 1'b0;
    oe_lost = 1'b0;
  end
  // 60 ns low before sampling: the device needs up to 30 ns to shift after a fall
  task automatic recv(input int n); // only called once a command is out
    for (int w = 0; w < n; w++) begin
      for (int b = 15; b >= 0; b--) begin
        #60;
        link_clk = 1'b1;
        rx[w][b] = link_dout;
        if (link_dout_oe !== 1'b1) oe_lost = 1'b1;
        #20;
        link_clk = 1'b0;
      end
    end
  endtask
endmodule
`default_nettype wire

// file: tb/tb_exec_response_formatter.sv
// testbench of the response formatter: registers, responses, reads, nvm cycles
`include "resp_regs.svh"
`default_nettype none
module tb_exec_response_formatter;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  wire logic   hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        link_clk;
  logic        link_dout;
  logic        link_dout_oe;
  logic        nvm_done = 1'b0;
  logic        nvm_start;
  int          err_count = 0;
  int          checks_done = 0;
  int          starts = 0;
  assign hready = hreadyout;
  always #5 clk = ~clk;
  always @(posedge clk) if (nvm_start === 1'b1) starts <= starts + 1;
  exec_response_formatter dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link_clk(link_clk),
    .link_dout(link_dout), .link_dout_oe(link_dout_oe), .nvm_done(nvm_done),
    .nvm_start(nvm_start));
  prog_model prog (.link_clk(link_clk), .link_dout(link_dout), .link_dout_oe(link_dout_oe));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: seen %08h expected %08h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    // only the watchdog ends a wait for hready
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
    chk(32'(hresp), 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask
  // no second frame may start after the one just taken
  task automatic wait_idle();
    repeat (10) @(posedge clk);
    chk(32'(link_dout_oe), 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] q;
    rd(`RESP_VER_OFS, q);
    chk(q, 32'(`RESP_VER_RST));
    rd(`RESP_NVM_OFS, q);
    chk(q, 32'(`RESP_NVM_RST));
    rd(12'h0FC, q);
    chk(q, 32'h0000_0000);
    wr(`RESP_VER_OFS, 32'h0000_0032);
    rd(`RESP_VER_OFS, q);
    chk(q, 32'h0000_0032);
  endtask
  task automatic t_cmds();
    logic [2:0]  kinds [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h4, 3'h7};
    logic [3:0]  ops [8] = '{4'h1, 4'h2, 4'h2, 4'h3, 4'h1, 4'h1, 4'h1, 4'h3};
    logic [7:0]  qes [8] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'hF0, 8'h32, 8'h0F, 8'h00};
    logic [3:0]  echo;
    logic [15:0] msk;
    logic [15:0] want;
    for (int i = 0; i < 8; i++) begin
      echo = 4'(i + 8);
      wr(`RESP_CMD_OFS, {16'h0000, 7'h00, i == 4, 1'b0, kinds[i], echo});
      prog.recv(2);
      // the error byte of an unknown command is left open
      msk = (ops[i] == `RESP_OP_UNKNOWN) ? 16'hFF00 : 16'hFFFF;
      want = {ops[i], echo, qes[i]} & msk;
      chk(32'(prog.rx[0] & msk), 32'(want));
      chk(32'(prog.rx[1]), 32'(`RESP_HDR_WORDS));
      wait_idle();
    end
  endtask
  task automatic t_busy();
    wr(`RESP_CMD_OFS, 32'h0000_0005);
    wr(`RESP_CMD_OFS, 32'h0000_0036);
    prog.recv(2);
    chk(32'(prog.rx[0]), 32'h0000_1500);
    wait_idle();
  endtask
  task automatic t_read(input int n, input bit feed);
    int          len;
    logic [31:0] q;
    len = 3 * ((n + 1) / 2) + 2;
    wr(`RESP_CMD_OFS, {16'(n), 9'h000, 3'h6, 4'h7});
    fork
      prog.recv(len);
      if (feed) for (int k = 0; k < len - 2; k++) begin
        for (int p = 0; p < 300; p++) begin
          rd(`RESP_STAT_OFS, q);
          if (q[2] === 1'b0) break;
        end
        wr(`RESP_DATA_OFS, 32'h0000_A000 + 32'(k));
      end
    join
    chk(32'(prog.rx[0]), 32'h0000_1700);
    chk(32'(prog.rx[1]), 32'(len));
    for (int k = 0; k < len - 2; k++) begin
      chk(32'(prog.rx[k + 2]), feed ? 32'h0000_A000 + 32'(k) : 32'h0);
    end
    wait_idle();
    rd(`RESP_STAT_OFS, q);
    chk(q & 32'h0000_000B, feed ? 32'h0 : 32'h0000_0008);
  endtask
  // erase, calibration word rewrite, then a row write, each ended by one nvm_done pulse and read once for bit 15 clear
  task automatic t_nvm();
    logic [31:0] q;
    logic [31:0] v;
    int          s0;
    for (int c = 0; c < 3; c++) begin
      v = (c == 0) ? 32'h0000_C042 : (c == 1) ? 32'h0000_C003 : 32'h0000_C001;
      s0 = starts;
      wr(`RESP_NVM_OFS, v);
      wr(`RESP_NVM_OFS, v);
      wr(`RESP_NVM_OFS, v & 32'h0000_7FFF);
      rd(`RESP_NVM_OFS, q);
      chk(q, v);
      chk(32'(starts - s0), 32'h1);
      @(posedge clk);
      nvm_done <= 1'b1;
      @(posedge clk);
      nvm_done <= 1'b0;
      rd(`RESP_NVM_OFS, q);
      chk(q, v & 32'h0000_7FFF);
    end
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_cmds();
    t_busy();
    t_read(3, 1'b1);
    t_read(2, 1'b1);
    t_read(1, 1'b0);
    t_nvm();
    chk(32'(prog.oe_lost), 32'h0);
    tally_and_finish();
  end
  // whole run needs roughly 50 us
  initial begin
    #300_000;
    err_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
